// ---- hdl/pfss_map.vh ----
// Constants for the power-fail and stop-mode sequencer.
// Assumes a 100 MHz core clock; ring oscillator arrives as a pin level.
`ifndef PFSS_MAP_VH
`define PFSS_MAP_VH
`define PFSS_CLK_MHZ 100
// Ring oscillator nominal 8 kHz, one step 125 us
`define PFSS_RING_STEP_US 125
// Wake timer width: 16 bits of 125 us steps, about 8 s
`define PFSS_WAKE_W 16
// Periodic monitor intervals in ring clocks (2^11, 2^12, 2^13)
`define PFSS_INT_W 14
`define PFSS_INT_2K 14'h0800
`define PFSS_INT_4K 14'h1000
`define PFSS_INT_8K 14'h2000
// Interval select codes
`define PFSS_SEL_CONT 2'h0
`define PFSS_SEL_2K 2'h1
`define PFSS_SEL_4K 2'h2
`define PFSS_SEL_8K 2'h3
// Detection window: two ring cycles powered, third confirms
`define PFSS_WIN_POWER 2'h2
`define PFSS_WIN_CONFIRM 2'h3
// Persistence in core cycles, crystal settle in core cycles
`define PFSS_PERSIST_W 12
`define PFSS_CRYST_W 16
// Fast release bound: under 20 crystal cycles
`define PFSS_FAST_REL 5'h10
// Resume address after power-fail reset
`define PFSS_RESUME_ADDR 16'h8000
// Reset value of the stop-mode monitor disable bit
`define PFSS_DIS_RST 1'b1
`endif

// ---- hdl/pfss_ring_tick.v ----
// Turns the synchronised ring oscillator level into one-cycle ticks.
// Assumes the ring clock is far slower than core_clk.
`timescale 1ns/1ps
module pfss_ring_tick
(
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // Ring level, already synchronised
   input wire ring_lvl,
   output wire ring_tick
);
   reg ring_last;

   always @(posedge core_clk)
   begin
      if (sys_rst)
         ring_last <= 1'b0;
      else
         ring_last <= ring_lvl;
   end

   assign ring_tick = ring_lvl & ~ring_last;
endmodule // pfss_ring_tick

// ---- hdl/pfss_seq.v ----
// Power-fail supervision and stop-mode sequencer, top level.
// Assumes comparators, ring clock and reset sources are async pins.
`timescale 1ns/1ps
`include "pfss_map.vh"
module pfss_seq #(
   parameter PERSIST_CYC = 12'h064,
   parameter CRYST_CYC = 16'h1000
)
(
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // Analogue comparators and ring clock (async)
   input wire below_warning,
   input wire below_reset,
   input wire below_poweron,
   input wire ring_clk,
   // Other reset sources (async, active low pin, high watchdog)
   input wire ext_reset_n,
   input wire wdog_reset,
   // CPU side
   input wire stop_req,
   input wire io_irq,
   input wire stop_monitor_disable_wr,
   input wire stop_monitor_disable_in,
   input wire [1:0] interval_sel,
   input wire [15:0] wake_timeout,
   input wire wake_enable,
   input wire warn_irq_enable,
   input wire warn_flag_clear,
   output reg stop_monitor_disable,
   output reg power_warning_flag,
   output wire warn_irq,
   output reg in_stop,
   output wire cpu_halt,
   output reg cpu_reset,
   output reg [15:0] resume_addr,
   output reg resume_load,
   // Analogue enables
   output reg monitor_en,
   output reg regulator_en,
   output reg crystal_en
);
   localparam ST_RUN = 3'h0;
   localparam ST_STOP = 3'h1;
   localparam ST_WARM = 3'h2;
   localparam ST_PFAIL = 3'h3;
   localparam ST_OFF = 3'h4;
   localparam ST_FAST = 3'h5;

   wire [4:0] raw_in;
   wire [4:0] syn;
   wire ring_tick;
   wire s_warn = syn[0];
   wire s_rst = syn[1];
   wire s_por = ~syn[2];
   wire s_ext = syn[3];
   wire s_wdog = syn[4];
   reg [2:0] state;
   reg [2:0] next_state;
   reg [`PFSS_PERSIST_W-1:0] warn_cnt;
   reg [`PFSS_PERSIST_W-1:0] rst_cnt;
   reg [`PFSS_CRYST_W-1:0] warm_cnt;
   reg [`PFSS_WAKE_W-1:0] wake_cnt;
   reg [`PFSS_INT_W-1:0] per_cnt;
   reg [1:0] win_cnt;
   reg [4:0] fast_cnt;
   reg win_active;
   reg [`PFSS_INT_W-1:0] per_limit;
   wire mon_live;
   wire warn_seen;
   wire rst_seen;
   wire wake_hit;

   // comparators synchronised
   // Power-on and pin inverted: a flushed synchroniser reads as held off for power-on, released for the pin
   assign raw_in = {wdog_reset, ~ext_reset_n, ~below_poweron, below_reset,
                    below_warning};

   pfss_sync #(.W(5)) u_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in(raw_in),
      .sync_out(syn)
   );

   wire [0:0] ring_syn;
   pfss_sync #(.W(1)) u_ring_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in(ring_clk),
      .sync_out(ring_syn)
   );

   pfss_ring_tick u_tick (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .ring_lvl(ring_syn[0]),
      .ring_tick(ring_tick)
   );

   // monitor live in run; in stop only while stop_monitor_disable is clear
   assign mon_live = (state == ST_STOP) ? ~stop_monitor_disable :
                     (state != ST_PFAIL) && (state != ST_OFF);

   assign warn_seen = mon_live && (warn_cnt == PERSIST_CYC);
   assign rst_seen = mon_live && (rst_cnt == PERSIST_CYC);
   assign wake_hit = (state == ST_STOP) && wake_enable && ring_tick &&
                     (wake_cnt == wake_timeout);

   // stopped or reset means no execution
   assign cpu_halt = (state != ST_RUN);
   assign warn_irq = power_warning_flag & warn_irq_enable;

   always @*
   begin
      case (interval_sel)
         `PFSS_SEL_2K: per_limit = `PFSS_INT_2K;
         `PFSS_SEL_4K: per_limit = `PFSS_INT_4K;
         `PFSS_SEL_8K: per_limit = `PFSS_INT_8K;
         default: per_limit = {`PFSS_INT_W{1'b0}};
      endcase
   end

   always @*
   begin
      next_state = state;
      case (state)
         ST_RUN:
         begin
            if (stop_req)
               next_state = ST_STOP;
         end
         ST_STOP:
         begin
            if (io_irq || warn_seen || wake_hit)
               next_state = ST_WARM;
         end
         ST_WARM:
         begin
            if (warm_cnt == CRYST_CYC)
               next_state = ST_RUN;
         end
         ST_PFAIL:
         begin
            if (ring_tick && win_active && win_cnt == `PFSS_WIN_CONFIRM
                && !s_rst)
               next_state = ST_WARM;
            else if (per_limit == {`PFSS_INT_W{1'b0}} && !s_rst
                     && ring_tick)
               next_state = ST_WARM;
         end
         ST_OFF:
         begin
            if (!s_por)
               next_state = ST_PFAIL;
         end
         ST_FAST:
         begin
            if (!s_ext && !s_wdog && fast_cnt == `PFSS_FAST_REL)
               next_state = ST_RUN;
         end
         default: next_state = ST_OFF;
      endcase
      if (rst_seen && state != ST_PFAIL)
         next_state = ST_PFAIL;
      if ((s_ext || s_wdog) && (state == ST_RUN || state == ST_WARM))
         next_state = ST_FAST;
      if (s_por)
         next_state = ST_OFF;
   end

   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state <= ST_OFF;
         stop_monitor_disable <= `PFSS_DIS_RST;
         power_warning_flag <= 1'b0;
         warn_cnt <= {`PFSS_PERSIST_W{1'b0}};
         rst_cnt <= {`PFSS_PERSIST_W{1'b0}};
         warm_cnt <= {`PFSS_CRYST_W{1'b0}};
         wake_cnt <= {`PFSS_WAKE_W{1'b0}};
         per_cnt <= {`PFSS_INT_W{1'b0}};
         win_cnt <= 2'h0;
         win_active <= 1'b0;
         fast_cnt <= 5'h00;
         resume_addr <= 16'h0000;
         resume_load <= 1'b0;
      end
      else
      begin
         state <= next_state;
         resume_load <= 1'b0;
         if (stop_monitor_disable_wr)
            stop_monitor_disable <= stop_monitor_disable_in;
         if (mon_live && s_warn && !s_rst)
         begin
            if (warn_cnt != PERSIST_CYC)
               warn_cnt <= warn_cnt + 1'b1;
         end
         else
            warn_cnt <= {`PFSS_PERSIST_W{1'b0}};
         if (mon_live && s_rst)
         begin
            if (rst_cnt != PERSIST_CYC)
               rst_cnt <= rst_cnt + 1'b1;
         end
         else
            rst_cnt <= {`PFSS_PERSIST_W{1'b0}};
         // sticky warning flag, set beats clear
         if (warn_seen)
            power_warning_flag <= 1'b1;
         else if (warn_flag_clear)
            power_warning_flag <= 1'b0;
         if (state != ST_STOP)
            wake_cnt <= {`PFSS_WAKE_W{1'b0}};
         else if (ring_tick)
            wake_cnt <= wake_cnt + 1'b1;
         if (next_state == ST_WARM && state != ST_WARM)
            warm_cnt <= {`PFSS_CRYST_W{1'b0}};
         else if (state == ST_WARM)
            warm_cnt <= warm_cnt + 1'b1;
         if (state == ST_FAST)
         begin
            if (s_ext || s_wdog)
               fast_cnt <= 5'h00;
            else
               fast_cnt <= fast_cnt + 1'b1;
         end
         else
            fast_cnt <= 5'h00;
         if (state != ST_PFAIL)
         begin
            per_cnt <= {`PFSS_INT_W{1'b0}};
            win_active <= 1'b0;
            win_cnt <= 2'h0;
         end
         else if (ring_tick)
         begin
            if (win_active)
            begin
               if (win_cnt == `PFSS_WIN_POWER && s_rst)
                  win_active <= 1'b0;
               else if (win_cnt == `PFSS_WIN_CONFIRM)
                  win_active <= 1'b0;
               win_cnt <= win_cnt + 1'b1;
               per_cnt <= {`PFSS_INT_W{1'b0}};
            end
            else if (per_cnt == per_limit - 1'b1)
            begin
               win_active <= 1'b1;
               win_cnt <= 2'h1;
               per_cnt <= {`PFSS_INT_W{1'b0}};
            end
            else
               per_cnt <= per_cnt + 1'b1;
         end
         // resume at fixed address after power-fail
         if (state == ST_PFAIL && next_state == ST_WARM)
         begin
            resume_addr <= `PFSS_RESUME_ADDR;
            resume_load <= 1'b1;
         end
      end
   end

   // Analogue enables and CPU reset follow the state
   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         in_stop <= 1'b0;
         cpu_reset <= 1'b1;
         monitor_en <= 1'b0;
         regulator_en <= 1'b0;
         crystal_en <= 1'b0;
      end
      else
      begin
         in_stop <= (next_state == ST_STOP);
         cpu_reset <= (next_state == ST_PFAIL) || (next_state == ST_OFF) ||
                      (next_state == ST_FAST) ||
                      (next_state == ST_WARM && state == ST_PFAIL) ||
                      (state == ST_WARM && cpu_reset &&
                       next_state == ST_WARM);
         // regulator and crystal off in power-fail
         regulator_en <= (next_state == ST_RUN) ||
                         (next_state == ST_WARM) || (next_state == ST_FAST);
         crystal_en <= (next_state == ST_RUN) ||
                       (next_state == ST_WARM) || (next_state == ST_FAST);
         // comparator powered during window or continuous
         monitor_en <= (next_state == ST_PFAIL) ?
                       (win_active || per_limit == {`PFSS_INT_W{1'b0}}) :
                       (next_state == ST_STOP) ? ~stop_monitor_disable :
                       (next_state != ST_OFF);
      end
   end
endmodule // pfss_seq

// ---- hdl/pfss_sync.v ----
// Two-flop synchroniser for asynchronous level inputs.
// Assumes all inputs are static levels relative to core_clk.
`timescale 1ns/1ps
module pfss_sync #(
   parameter W = 1
)
(
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // Data
   input wire [W-1:0] async_in,
   output reg [W-1:0] sync_out
);
   reg [W-1:0] stage1;

   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         stage1 <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end
      else
      begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule // pfss_sync

// ---- tb/pfss_analog.sv ----
// Model of the supply comparators and the ring oscillator.
// Assumes the bench sets a supply level; ring runs free, shortened.
`timescale 1ns/1ps
module pfss_analog
(
   // Supply: 0 good, 1 warning zone, 2 reset zone, 3 below power-on
   input wire [1:0] supply_lvl,
   input wire monitor_en,
   // Comparators and ring
   output reg below_warning,
   output reg below_reset,
   output wire below_poweron,
   output reg ring_clk
);
   initial
   begin
      ring_clk = 1'b0;
      forever #25.3 ring_clk = ~ring_clk;
   end
   assign below_poweron = (supply_lvl == 2'h3);
   initial
   begin
      below_warning = 1'b0;
      below_reset = 1'b0;
      forever
      begin
         #3;
         below_warning = monitor_en ? (supply_lvl != 2'h0) : ~below_warning;
         below_reset = monitor_en ? supply_lvl[1] : ~below_reset;
      end
   end
endmodule // pfss_analog

// ---- tb/pfss_seq_assertions.sv ----
// Port-level checker for the power-fail and stop sequencer.
// Assumes it is bound onto pfss_seq and sees only its ports.
`timescale 1ns/1ps
module pfss_chk #(
   parameter PERSIST_CYC = 12'h064,
   parameter CRYST_CYC = 16'h1000
)
(
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // Inputs watched
   input wire ext_reset_n,
   input wire wdog_reset,
   input wire stop_req,
   input wire warn_irq_enable,
   // Outputs watched
   input wire stop_monitor_disable,
   input wire power_warning_flag,
   input wire warn_irq,
   input wire in_stop,
   input wire cpu_halt,
   input wire cpu_reset,
   input wire [15:0] resume_addr,
   input wire resume_load,
   input wire monitor_en,
   input wire regulator_en,
   input wire crystal_en
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   AST_DIS_RST: assert property ($fell(sys_rst) |-> stop_monitor_disable)
      else $error("disable bit low after reset");
   AST_IRQ: assert property (warn_irq == (power_warning_flag && warn_irq_enable))
      else $error("warning interrupt mismatch");
   AST_HALT: assert property (in_stop |-> cpu_halt)
      else $error("running while in stop");
   AST_RUN_ON: assert property (!cpu_halt |-> monitor_en && regulator_en && crystal_en)
      else $error("supply off while running");
   AST_STOP_OFF: assert property (in_stop && stop_monitor_disable |-> !monitor_en && !cpu_reset)
      else $error("monitor active in stop");
   AST_ENTER: assert property (!cpu_halt && !cpu_reset && stop_req && ext_reset_n
      && !wdog_reset |=> in_stop)
      else $error("stop request not taken");
   AST_RESUME: assert property (resume_load |-> resume_addr == 16'h8000 && cpu_reset)
      else $error("bad resume address");
   AST_PULSE: assert property (resume_load |=> !resume_load)
      else $error("resume load too long");
   AST_FAST: assert property ($rose(ext_reset_n) && !wdog_reset && regulator_en
      |-> ##[1:19] !cpu_reset)
      else $error("slow release after pin reset");
   cover property (in_stop);
   cover property (resume_load);
   cover property ($rose(power_warning_flag));
   cover property (in_stop && !stop_monitor_disable);
endmodule // pfss_chk
bind pfss_seq pfss_chk #(.PERSIST_CYC(PERSIST_CYC), .CRYST_CYC(CRYST_CYC)) u_chk (
   .core_clk(core_clk), .sys_rst(sys_rst), .ext_reset_n(ext_reset_n),
   .wdog_reset(wdog_reset), .stop_req(stop_req),
   .warn_irq_enable(warn_irq_enable),
   .stop_monitor_disable(stop_monitor_disable),
   .power_warning_flag(power_warning_flag), .warn_irq(warn_irq),
   .in_stop(in_stop), .cpu_halt(cpu_halt), .cpu_reset(cpu_reset),
   .resume_addr(resume_addr), .resume_load(resume_load),
   .monitor_en(monitor_en), .regulator_en(regulator_en),
   .crystal_en(crystal_en));

// ---- tb/tb_top.sv ----
// Self-checking bench for the power-fail and stop sequencer.
// Assumes shortened persistence and crystal counts, fast ring model.
`timescale 1ns/1ps
module tb_top;
   reg core_clk, sys_rst, ext_reset_n, wdog_reset, stop_req, io_irq;
   reg dis_wr, dis_in, wake_enable, warn_irq_enable, warn_flag_clear;
   reg [1:0] interval_sel, supply_lvl;
   reg [15:0] wake_timeout;
   wire bw, br, bp, ring_clk, stop_monitor_disable, power_warning_flag;
   wire warn_irq, in_stop, cpu_halt, cpu_reset, resume_load;
   wire monitor_en, regulator_en, crystal_en;
   wire [15:0] resume_addr;
   int n_mismatch = 0, samples_checked = 0, ticks = 0, wn, t0, i;
   int ivq[$] = '{0, 2048, 4096, 8192};
   logic [31:0] rs = 32'h33;

   pfss_analog ana (.supply_lvl(supply_lvl), .monitor_en(monitor_en),
      .below_warning(bw), .below_reset(br), .below_poweron(bp),
      .ring_clk(ring_clk));
   pfss_seq #(.PERSIST_CYC(12'h004), .CRYST_CYC(16'h0008)) uut (
      .core_clk(core_clk), .sys_rst(sys_rst), .below_warning(bw),
      .below_reset(br), .below_poweron(bp), .ring_clk(ring_clk),
      .ext_reset_n(ext_reset_n), .wdog_reset(wdog_reset),
      .stop_req(stop_req), .io_irq(io_irq),
      .stop_monitor_disable_wr(dis_wr), .stop_monitor_disable_in(dis_in),
      .interval_sel(interval_sel), .wake_timeout(wake_timeout),
      .wake_enable(wake_enable), .warn_irq_enable(warn_irq_enable),
      .warn_flag_clear(warn_flag_clear),
      .stop_monitor_disable(stop_monitor_disable),
      .power_warning_flag(power_warning_flag), .warn_irq(warn_irq),
      .in_stop(in_stop), .cpu_halt(cpu_halt), .cpu_reset(cpu_reset),
      .resume_addr(resume_addr), .resume_load(resume_load),
      .monitor_en(monitor_en), .regulator_en(regulator_en),
      .crystal_en(crystal_en));

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge ring_clk) ticks++;

   task stop_test;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task neg(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   function logic cond(input int k);
      case (k)
         0: cond = !cpu_halt;
         1: cond = resume_load;
         2: cond = monitor_en;
         3: cond = !in_stop;
         default: cond = !cpu_reset;
      endcase
   endfunction
   // Bounded wait; wn holds the cycles spent
   task waitc(input int k, input int lim);
      wn = 0;
      while (cond(k) !== 1'b1 && wn < lim)
      begin
         @(posedge core_clk);
         #1;
         wn++;
      end
      chk(cond(k), 1);
      neg(1);
   endtask
   function logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
   endfunction

   initial
   begin
      #1000000;
      n_mismatch++;
      stop_test();
   end

   initial
   begin
      {sys_rst, ext_reset_n} = 2'h3;
      {wdog_reset, stop_req, io_irq, dis_wr, dis_in} = 5'h0;
      {wake_enable, warn_irq_enable, warn_flag_clear} = 3'h0;
      interval_sel = 2'h0;
      supply_lvl = 2'h3;
      wake_timeout = 16'h0000;
      neg(8);
      sys_rst = 1'b0;
      neg(10);
      chk(stop_monitor_disable, 1);
      chk({cpu_reset, monitor_en, regulator_en, crystal_en}, 4'h8);
      supply_lvl = 2'h0;
      waitc(0, 2000);
      chk({monitor_en, regulator_en, crystal_en, cpu_halt}, 4'hE);
      supply_lvl = 2'h1;
      neg(2);
      supply_lvl = 2'h0;
      neg(10);
      chk(power_warning_flag, 0);
      warn_irq_enable = 1'b1;
      supply_lvl = 2'h1;
      neg(20);
      chk({power_warning_flag, warn_irq, cpu_halt}, 3'h6);
      supply_lvl = 2'h0;
      neg(6);
      warn_flag_clear = 1'b1;
      neg(1);
      warn_flag_clear = 1'b0;
      neg(1);
      chk({power_warning_flag, warn_irq}, 2'h0);
      // Reset-level supply in stop must go unseen with the monitor off
      stop_req = 1'b1;
      neg(1);
      stop_req = 1'b0;
      neg(2);
      chk(in_stop, 1);
      supply_lvl = 2'h2;
      neg(50);
      chk({in_stop, cpu_reset, power_warning_flag}, 3'h4);
      supply_lvl = 2'h0;
      neg(5);
      io_irq = 1'b1;
      neg(3);
      io_irq = 1'b0;
      waitc(0, 200);
      rs = xs(rs);
      wake_timeout = {12'h000, rs[3:0]} + 16'h0003;
      wake_enable = 1'b1;
      stop_req = 1'b1;
      neg(1);
      stop_req = 1'b0;
      t0 = ticks;
      waitc(3, 3000);
      chk(ticks - t0 >= wake_timeout && ticks - t0 <= wake_timeout + 2, 1);
      wake_enable = 1'b0;
      waitc(0, 200);
      // Monitor left on in stop: a warning must wake the core
      dis_in = 1'b0;
      dis_wr = 1'b1;
      neg(1);
      dis_wr = 1'b0;
      stop_req = 1'b1;
      neg(1);
      stop_req = 1'b0;
      neg(1);
      chk({stop_monitor_disable, in_stop, monitor_en, power_warning_flag},
          4'h6);
      supply_lvl = 2'h1;
      waitc(3, 200);
      chk(power_warning_flag, 1);
      warn_flag_clear = 1'b1;
      neg(1);
      warn_flag_clear = 1'b0;
      neg(1);
      chk(power_warning_flag, 1);
      supply_lvl = 2'h0;
      waitc(0, 200);
      for (i = 0; i < 2; i++)
      begin
         ext_reset_n = i[0];
         wdog_reset = i[0];
         neg(10);
         chk({cpu_reset, monitor_en, regulator_en, crystal_en}, 4'hF);
         ext_reset_n = 1'b1;
         wdog_reset = 1'b0;
         waitc(4, 100);
         chk(wn < 20, 1);
      end
      for (i = 0; i < 4; i++)
      begin
         interval_sel = i[1:0];
         supply_lvl = 2'h2;
         neg(30);
         chk({cpu_reset, regulator_en, crystal_en}, 3'h4);
         chk(monitor_en, i == 0);
         supply_lvl = 2'h0;
         t0 = ticks;
         if (i > 0)
         begin
            waitc(2, 50000);
            chk(ticks - t0 + 10 >= ivq[i] && ticks - t0 <= ivq[i] + 2, 1);
            t0 = ticks;
         end
         waitc(1, 300);
         chk(resume_addr, 16'h8000);
         if (i > 0)
            chk(ticks - t0 >= 1 && ticks - t0 <= 4, 1);
         waitc(0, 300);
         chk(wn >= 8, 1);
      end
      stop_test();
   end
endmodule // tb_top
